/* File: design/strap_pin_select_defines.vh */
// Header of offsets, field positions, reset values and mode, rate and response codes for the strap/pin-select block.
// Assumes inclusion by bare name from design files only.
`ifndef STRAP_PIN_SELECT_DEFINES_VH
`define STRAP_PIN_SELECT_DEFINES_VH

// Register byte addresses
`define ADDR_FUNC_CTRL      8'h00
`define ADDR_DRIVE_OUT      8'h04
`define ADDR_IDE_CFG        8'h08
`define ADDR_MODE_STATUS    8'h0C
`define ADDR_ENCODE_CTRL    8'h10

// function_control_reg fields
`define FUNC_CTRL_ACK_BIT   1
`define FUNC_CTRL_FMT_BIT   7
`define FUNC_CTRL_RESET     8'h00

// drive_output_reg fields
`define DRIVE_OUT_DMA_BIT   3
`define DRIVE_OUT_RESET     8'h00

// IDE configuration fields
`define IDECFG_EN_BIT       0
`define IDECFG_SEC_BIT      1
`define IDECFG_RESET        8'h01

// Encoding control: bit 0 high selects modified-frequency encoding
`define ENC_MOD_FREQ_BIT    0
`define ENC_RESET           8'h00

// Mode codes, one-hot
`define MODE_BASIC_AT       4'h1
`define MODE_ENHANCED       4'h2
`define MODE_COMPACT        4'h4
`define MODE_ILLEGAL        4'h8

// Data-rate codes needing density polarity handling (500 kbs, 1 Mbs)
`define RATE_500K           2'h0
`define RATE_1M             2'h3

// AXI response codes
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: design/ide_access_decode.v */
// IDE address decoder: drive register ranges and the bit-7 shared addresses.
// Assumes a 10-bit ISA I/O address, valid while an access strobe is high.
`timescale 1ns/100ps
module ide_access_decode (
    input  wire [9:0] ioAddr,
    input  wire       secondary,
    output wire       hitTaskFile,
    output wire       hitBit7
);
    // Primary 1F0-1F7h, secondary 170-177h
    assign hitTaskFile = secondary ? (ioAddr[9:3] == 7'h2E) : (ioAddr[9:3] == 7'h3E);
    // Primary 3F7h, secondary 377h
    assign hitBit7     = secondary ? (ioAddr == 10'h377) : (ioAddr == 10'h3F7);
endmodule // ide_access_decode

/* File: design/strap_mode_and_pin_select.v */
// Contract
// - Function control bit 1 set makes the shared pin the IDE DMA acknowledge.
// - While that pin is DMA acknowledge, density select is active high.
// - Function control bit 1 clear makes the shared pin the host-type strap.
// - Lower byte enable on hard-drive accesses; inactive when IDE is disabled.
// - Upper byte enable only when the drive signals 16-bit capability.
// - Bit-7 line serves 3F7h/377h accesses beside the drive register ranges.
// - Straps sampled at reset pick basic, enhanced, compact or illegal mode.
// - Basic mode honours DMA enable, end-count active high, status A/B off.
// - Enhanced mode treats DMA as always enabled.
// - Host-type strap sets density polarity for 500 kbs and 1 Mbs rates.
// - Function control bit 7 clear makes the pin the open-drain channel-ready.
// - Function control bit 7 set makes the pin the encoding-format output.
// - In EPP, pull channel-ready low to stretch the host cycle.
// - Encoding format high for modified-frequency, low for single, low after reset.
//
// Strap sampling, shared-pin selection and IDE enables, AXI4-Lite registers.
// Assumes straps are stable and synchronous to clk_sys through the first clk_sys edge after rstn rises.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "strap_pin_select_defines.vh"
module strap_mode_and_pin_select (
    input  wire        clk_sys,
    input  wire        rstn,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Shared pin: host-type strap or IDE DMA acknowledge
    input  wire        identAckPin,
    output wire        ideDmaAck,
    // Shared pin: encoding format or channel-ready wait (two-way)
    input  wire        formatPinIn,
    output wire        formatPinOut,
    output wire        formatPinOe,
    // Floppy side
    input  wire [1:0]  dataRate,
    input  wire        fdcDmaReq,
    input  wire        transferCountEnd,
    output wire        dmaReqOut,
    output wire        transferEndInt,
    output wire        densitySelect,
    output wire        statusAbEnable,
    // EPP wait request
    input  wire        eppWaitReq,
    // ISA / IDE side
    input  wire [9:0]  ioAddr,
    input  wire        ioRead,
    input  wire        ioWrite,
    input  wire        iocs16n,
    output wire        ideLowerByteEnableN,
    output wire        ideUpperByteEnableN,
    input  wire        ideBit7In,
    output wire        ideBit7Out,
    output wire        ideBit7Oe,
    input  wire        hostBit7In,
    output wire        hostBit7Out,
    output wire        hostBit7Oe
);
    localparam ST_RESET = 2'h1;
    localparam ST_RUN   = 2'h2;

    reg  [1:0]  state_ff;
    reg  [3:0]  mode_ff;
    reg         hostType_ff;
    reg  [7:0]  funcCtrl_ff;
    reg  [7:0]  driveOut_ff;
    reg  [7:0]  ideCfg_ff;
    reg  [7:0]  encCtrl_ff;
    reg         awHeld_ff;
    reg  [7:0]  awAddr_ff;
    reg         wHeld_ff;
    reg  [31:0] wData_ff;
    reg  [3:0]  wStrb_ff;
    reg         bValid_ff;
    reg  [1:0]  bResp_ff;
    reg         rValid_ff;
    reg  [31:0] rData_ff;
    reg  [1:0]  rResp_ff;
    reg  [3:0]  nxt_mode;
    reg  [1:0]  nxt_state;

    wire hitTaskFile;
    wire hitBit7;
    wire ideEnable  = ideCfg_ff[`IDECFG_EN_BIT];
    wire ackMode    = funcCtrl_ff[`FUNC_CTRL_ACK_BIT];
    wire formatMode = funcCtrl_ff[`FUNC_CTRL_FMT_BIT];

    function [3:0] decodeMode;
        input hostType;
        input encStrap;
        begin
            case ({hostType, encStrap})
                2'h3:    decodeMode = `MODE_BASIC_AT;
                2'h2:    decodeMode = `MODE_ILLEGAL;
                2'h1:    decodeMode = `MODE_ENHANCED;
                default: decodeMode = `MODE_COMPACT;
            endcase
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `ADDR_FUNC_CTRL) || (addr == `ADDR_DRIVE_OUT) ||
                     (addr == `ADDR_IDE_CFG) || (addr == `ADDR_MODE_STATUS) ||
                     (addr == `ADDR_ENCODE_CTRL);
        end
    endfunction

    ide_access_decode u_decode (
        .ioAddr      (ioAddr),
        .secondary   (ideCfg_ff[`IDECFG_SEC_BIT]),
        .hitTaskFile (hitTaskFile),
        .hitBit7     (hitBit7)
    );

    // Strap capture: sample while reset state, freeze on first run cycle
    always @* begin
        nxt_state = state_ff;
        nxt_mode  = mode_ff;
        case (state_ff)
            ST_RESET: begin
                nxt_mode  = decodeMode(identAckPin, formatPinIn);
                nxt_state = ST_RUN;
            end
            ST_RUN:  nxt_state = ST_RUN;
            default: nxt_state = ST_RESET;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff    <= ST_RESET;
            mode_ff     <= `MODE_BASIC_AT;
            hostType_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            mode_ff  <= nxt_mode;
            if (state_ff == ST_RESET) begin
                hostType_ff <= identAckPin;
            end
        end
    end

    // Write channel: address and data accepted in either order
    wire wrFire = awHeld_ff && wHeld_ff && !bValid_ff;
    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready  = !wHeld_ff && !bValid_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bResp_ff;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awHeld_ff   <= 1'b0;
            awAddr_ff   <= 8'h00;
            wHeld_ff    <= 1'b0;
            wData_ff    <= 32'h00000000;
            wStrb_ff    <= 4'h0;
            bValid_ff   <= 1'b0;
            bResp_ff    <= `RESP_OKAY;
            funcCtrl_ff <= `FUNC_CTRL_RESET;
            driveOut_ff <= `DRIVE_OUT_RESET;
            ideCfg_ff   <= `IDECFG_RESET;
            encCtrl_ff  <= `ENC_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff  <= 1'b0;
                bValid_ff <= 1'b1;
                bResp_ff  <= mapped(awAddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
                if (wStrb_ff[0]) begin
                    case (awAddr_ff)
                        `ADDR_FUNC_CTRL:   funcCtrl_ff <= wData_ff[7:0];
                        `ADDR_DRIVE_OUT:   driveOut_ff <= wData_ff[7:0];
                        `ADDR_IDE_CFG:     ideCfg_ff   <= wData_ff[7:0];
                        `ADDR_ENCODE_CTRL: encCtrl_ff  <= wData_ff[7:0];
                        default:           encCtrl_ff  <= encCtrl_ff;
                    endcase
                end
            end else if (bValid_ff && s_axi_bready) begin
                bValid_ff <= 1'b0;
            end
        end
    end

    // Read channel
    assign s_axi_arready = !rValid_ff;
    assign s_axi_rvalid  = rValid_ff;
    assign s_axi_rdata   = rData_ff;
    assign s_axi_rresp   = rResp_ff;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rValid_ff <= 1'b0;
            rData_ff  <= 32'h00000000;
            rResp_ff  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_ff <= 1'b1;
            rResp_ff  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `ADDR_FUNC_CTRL:   rData_ff <= {24'h000000, funcCtrl_ff};
                `ADDR_DRIVE_OUT:   rData_ff <= {24'h000000, driveOut_ff};
                `ADDR_IDE_CFG:     rData_ff <= {24'h000000, ideCfg_ff};
                `ADDR_MODE_STATUS: rData_ff <= {27'h0000000, hostType_ff, mode_ff};
                `ADDR_ENCODE_CTRL: rData_ff <= {24'h000000, encCtrl_ff};
                default:           rData_ff <= 32'h00000000;
            endcase
        end else if (rValid_ff && s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    // Shared pin 54
    assign ideDmaAck = ackMode & identAckPin;

    // Mode-dependent DMA and status A/B handling; end count passes straight through
    wire dmaEnBit = driveOut_ff[`DRIVE_OUT_DMA_BIT];
    wire enhanced = (mode_ff == `MODE_ENHANCED);
    assign dmaReqOut      = fdcDmaReq & (enhanced | dmaEnBit);
    assign transferEndInt = transferCountEnd;
    assign statusAbEnable = enhanced;

    // Density select polarity for the high rates
    wire highRate  = (dataRate == `RATE_500K) || (dataRate == `RATE_1M);
    wire activeHi  = ackMode | hostType_ff;
    assign densitySelect = activeHi ? highRate : ~highRate;

    // Shared pin 53: format output or open-drain channel ready
    wire modFreqLevel = (state_ff == ST_RUN) & encCtrl_ff[`ENC_MOD_FREQ_BIT];
    assign formatPinOut = formatMode ? modFreqLevel : 1'b0;
    assign formatPinOe  = formatMode ? (state_ff == ST_RUN)
                                     : eppWaitReq;

    // IDE byte enables, active low
    wire ideAccess = ideEnable & (ioRead | ioWrite) & (hitTaskFile | hitBit7);
    assign ideLowerByteEnableN = ~ideAccess;
    assign ideUpperByteEnableN = ~(ideAccess & hitTaskFile & ~iocs16n);

    // Bit 7 pass-through for 3F7h/377h
    wire bit7Access = ideEnable & hitBit7;
    assign ideBit7Out  = hostBit7In;
    assign ideBit7Oe   = bit7Access & ioWrite;
    assign hostBit7Out = ideBit7In;
    assign hostBit7Oe  = bit7Access & ioRead;
endmodule // strap_mode_and_pin_select

/* File: test/strap_pin_select_sva.sv */
// Checker: shared-pin, DMA and IDE enable relations at the top ports.
// Assumes control registers are shadowed from low bytes of completed AXI writes.
`timescale 1ns/100ps
module strap_pin_select_sva (
    input wire logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, identAckPin, ideDmaAck,
    input wire logic        densitySelect, formatPinOut, formatPinOe, eppWaitReq, fdcDmaReq,
    input wire logic        transferCountEnd, transferEndInt, dmaReqOut, statusAbEnable,
    input wire logic        ioRead, ioWrite, iocs16n, ideLowerByteEnableN, ideUpperByteEnableN,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [1:0]  dataRate
);
    logic [7:0] addr_ff, data_ff, fcr_ff, cfg_ff;
    logic [1:0] age_ff;
    logic       pend_ff, quiet;
    // Judge register-dependent pins only when no write is in flight
    assign quiet = !(s_axi_awvalid || s_axi_wvalid || s_axi_bvalid || pend_ff);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {addr_ff, data_ff, fcr_ff, cfg_ff} <= 32'h00000001;
            {pend_ff, age_ff} <= 3'h0;
        end else begin
            if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
            if (s_axi_awvalid && s_axi_awready) addr_ff <= s_axi_awaddr;
            if (s_axi_awvalid && s_axi_awready) pend_ff <= 1'b1;
            if (s_axi_wvalid && s_axi_wready) data_ff <= s_axi_wdata[7:0];
            if (s_axi_bvalid && s_axi_bready) begin
                pend_ff <= 1'b0;
                if (addr_ff == 8'h00) fcr_ff <= data_ff;
                if (addr_ff == 8'h08) cfg_ff <= data_ff;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_ackOn; quiet && fcr_ff[1] |-> ideDmaAck == identAckPin; endproperty
    a_ackOn: assert property (p_ackOn) else $error("ack not routed");
    property p_ackOff; quiet && !fcr_ff[1] |-> !ideDmaAck; endproperty
    a_ackOff: assert property (p_ackOff) else $error("ack while strap");
    property p_densAck; quiet && fcr_ff[1] && (dataRate == 2'h0 || dataRate == 2'h3)
        |-> densitySelect; endproperty
    a_densAck: assert property (p_densAck) else $error("density not high");
    property p_waitPin; quiet && !fcr_ff[7] |-> !formatPinOut && formatPinOe == eppWaitReq;
    endproperty
    a_waitPin: assert property (p_waitPin) else $error("wait pin wrong");
    property p_fmtPin; quiet && fcr_ff[7] && age_ff == 2'h3 |-> formatPinOe; endproperty
    a_fmtPin: assert property (p_fmtPin) else $error("format pin off");
    property p_endCnt; $rose(transferCountEnd) |-> $rose(transferEndInt); endproperty
    a_endCnt: assert property (p_endCnt) else $error("end count polarity");
    property p_dmaGate; !fdcDmaReq |-> !dmaReqOut; endproperty
    a_dmaGate: assert property (p_dmaGate) else $error("dma without request");
    property p_loIdle; !ioRead && !ioWrite |-> ideLowerByteEnableN; endproperty
    a_loIdle: assert property (p_loIdle) else $error("low byte idle");
    property p_ideOff; quiet && !cfg_ff[0] |-> ideLowerByteEnableN && ideUpperByteEnableN;
    endproperty
    a_ideOff: assert property (p_ideOff) else $error("ide disabled active");
    property p_hiNeed; !ideUpperByteEnableN |-> !iocs16n && !ideLowerByteEnableN; endproperty
    a_hiNeed: assert property (p_hiNeed) else $error("high byte no 16");
    property p_modeHold; age_ff == 2'h3 |=> $stable(statusAbEnable); endproperty
    a_modeHold: assert property (p_modeHold) else $error("mode changed");
endmodule // strap_pin_select_sva

bind strap_mode_and_pin_select strap_pin_select_sva u_sva (.*);

/* File: test/ide_drive_model.sv */
// IDE drive model: claims 16-bit transfers on its task file, answers on bit 7.
// Assumes the bench sets wide for a drive that accepts 16-bit accesses.
`timescale 1ns/100ps
module ide_drive_model (
    input  wire logic       wide,
    input  wire logic [9:0] ioAddr,
    input  wire logic       ideBit7Oe,
    input  wire logic       ideBit7Out,
    output wire logic       iocs16n,
    output wire logic       ideBit7In
);
    wire taskFile = (ioAddr[9:3] == 7'h3E) || (ioAddr[9:3] == 7'h2E);
    // Pulled up when the drive does not claim the cycle
    assign iocs16n = !(wide && taskFile);
    // Drive answers bit 7 low when the host side does not drive it
    assign ideBit7In = ideBit7Oe ? ideBit7Out : 1'b0;
endmodule // ide_drive_model

/* File: test/strap_mode_and_pin_select_tb.sv */
// Bench: strap modes, shared-pin selection and IDE enables over AXI4-Lite.
// Assumes the IDE drive model on the IDE side and the bench as host.
`timescale 1ns/100ps
module strap_mode_and_pin_select_tb;
    logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, identAckPin, ideDmaAck, formatPinIn, formatPinOut, formatPinOe;
    logic        fdcDmaReq, transferCountEnd, dmaReqOut, transferEndInt, densitySelect;
    logic        statusAbEnable, eppWaitReq, ioRead, ioWrite, iocs16n, ideLowerByteEnableN;
    logic        ideUpperByteEnableN, ideBit7In, ideBit7Out, ideBit7Oe, hostBit7In;
    logic        hostBit7Out, hostBit7Oe, fmtStrap, wide, hostBit7Drv;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, dataRate;
    logic [9:0]  ioAddr;
    int          fails, check_count;
    typedef struct { logic [7:0] function_control_reg, cfg, drive_output_reg; logic [9:0] addr; logic [1:0] rw;
                     logic ack, req, epp, wd; logic [4:0] exp; } row_t;
    // exp = {ideDmaAck, dmaReqOut, formatPinOe, lowN, highN}
    row_t rows[7] = '{'{8'h00, 8'h01, 8'h00, 10'h1F0, 2'h2, 1, 1, 1, 1, 5'h04},
                      '{8'h02, 8'h01, 8'h08, 10'h3F7, 2'h2, 1, 1, 0, 1, 5'h19},
                      '{8'h80, 8'h00, 8'h08, 10'h1F2, 2'h2, 0, 1, 1, 1, 5'h0F},
                      '{8'h82, 8'h03, 8'h00, 10'h170, 2'h1, 1, 0, 0, 0, 5'h15},
                      '{8'h00, 8'h03, 8'h00, 10'h1F0, 2'h2, 0, 0, 0, 1, 5'h03},
                      '{8'h00, 8'h03, 8'h08, 10'h377, 2'h1, 1, 1, 1, 1, 5'h0D},
                      '{8'h00, 8'h01, 8'h00, 10'h1F7, 2'h0, 1, 1, 0, 1, 5'h03}};
    logic [7:0]  modeExp[4] = '{8'h04, 8'h02, 8'h18, 8'h11};
    assign formatPinIn = formatPinOe ? formatPinOut : fmtStrap;
    assign hostBit7In = hostBit7Oe ? hostBit7Out : hostBit7Drv;
    strap_mode_and_pin_select u_dut (.*);
    ide_drive_model u_drive (.*);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic doReset(input logic h, input logic e);
        rstn <= 1'b0;
        identAckPin <= h;
        fmtStrap <= e;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {fdcDmaReq, transferCountEnd, eppWaitReq, ioRead, ioWrite, wide} = 6'h00;
        hostBit7Drv = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        dataRate = 2'h0;
        ioAddr = 10'h000;
        doReset(1'b1, 1'b1);
        foreach (rows[i]) begin
            axiWr(8'h00, {24'h0, rows[i].function_control_reg});
            axiWr(8'h08, {24'h0, rows[i].cfg});
            axiWr(8'h04, {24'h0, rows[i].drive_output_reg});
            {ioRead, ioWrite} <= rows[i].rw;
            {identAckPin, fdcDmaReq, eppWaitReq, wide} <= {rows[i].ack, rows[i].req,
                                                           rows[i].epp, rows[i].wd};
            ioAddr <= rows[i].addr;
            @(negedge clk_sys);
            chk("row pins", rows[i].exp, {ideDmaAck, dmaReqOut, formatPinOe,
                ideLowerByteEnableN, ideUpperByteEnableN});
        end
        @(posedge clk_sys);
        ioAddr <= 10'h3F7;
        {ioRead, ioWrite} <= 2'h1;
        hostBit7Drv <= 1'b1;
        @(negedge clk_sys);
        chk("bit7 write", 3'h6, {ideBit7Oe, ideBit7Out, hostBit7Oe});
        @(posedge clk_sys);
        {ioRead, ioWrite} <= 2'h2;
        @(negedge clk_sys);
        chk("bit7 read", 3'h2, {ideBit7Oe, hostBit7Oe, hostBit7Out});
        @(posedge clk_sys);
        {ioRead, ioWrite} <= 2'h0;
        axiWr(8'h00, 32'h80);
        @(negedge clk_sys);
        chk("format after reset", 2'h2, {formatPinOe, formatPinOut});
        axiWr(8'h10, 32'h1);
        @(negedge clk_sys);
        chk("format pin", 2'h3, {formatPinOe, formatPinOut});
        axiRd(8'h20, d, r);
        chk("unmapped resp", 2'h2, r);
        chk("unmapped data", 32'h0, d);
        for (int k = 3; k >= 0; k--) begin
            doReset(k[1], k[0]);
            identAckPin <= !k[1];
            fmtStrap <= !k[0];
            fdcDmaReq <= 1'b1;
            axiRd(8'h0C, d, r);
            chk("mode status", {24'h0, modeExp[k]}, d);
            chk("dma ab density", {k == 1, k == 1, k[1]},
                {dmaReqOut, statusAbEnable, densitySelect});
        end
        transferCountEnd <= 1'b1;
        axiWr(8'h00, 32'h2);
        @(negedge clk_sys);
        chk("density on ack", 2'h3, {densitySelect, transferEndInt});
        axiRd(8'h0C, d, r);
        chk("mode kept", 32'h04, d);
        finish_test();
    end
    initial begin
        #400000;
        fails++;
        finish_test();
    end
endmodule // strap_mode_and_pin_select_tb
